/* File: hdl/wts_map.vh */
// How it works
// - in week mode an entry covers a single weekday or a range given by start and end day codes.
// - an entry with only an off time forces the output off at that time on its selected days.
// - on days outside an entry's range that entry leaves the output as it was.
// - when entries collide in one second, the entry with the higher index wins.
// - week mode ignores the date field; day mode matches the date of every entry.
// - each entry holds a date, an on time setpoint and an off time setpoint.
// - the time counter keeps running whatever the state of main power.
// - the output goes on at an on setpoint and off at an off setpoint, if not already there.
// - the clock counts whole seconds and compares setpoints each second.
// - up to 127 entries are stored for the one output.
// - setpoints run from 00:00:00 to 23:59:59, held as one count of seconds from midnight.
// - a setpoint of 24:00:00 means not programmed and causes no edge.
// - the week runs Monday to Sunday and a range must not start after its end.
`ifndef WTS_MAP_VH
`define WTS_MAP_VH
// ==========================================
// register offsets
`define WTS_REG_CTRL     12'h000
`define WTS_REG_TIME     12'h004
`define WTS_REG_DATE     12'h008
`define WTS_REG_IDX      12'h00c
`define WTS_REG_ENT_TIME 12'h010
`define WTS_REG_ENT_DATE 12'h014
`define WTS_REG_STATUS   12'h018
`define WTS_REG_ENT_OFF  12'h020
// ==========================================
// fields and constants
`define WTS_CTRL_DAYMODE 0
`define WTS_CTRL_RUN     1
`define WTS_UNSET_TIME   17'h15180
`define WTS_DAY_SECONDS  17'h15180
`define WTS_CLK_HZ       50000000
`define WTS_TICK_S       1
`define WTS_ENTRIES      127
`define WTS_DAY_MON      3'h0
`define WTS_DAY_SUN      3'h6
`endif

/* File: hdl/wts_top.v */
// Chosen here: the address map and the AHB-Lite interface to the registers.
`include "wts_map.vh"
module wts_top #(
   parameter TICK_CYCLES = `WTS_CLK_HZ * `WTS_TICK_S,
   parameter ENTRIES     = `WTS_ENTRIES
) (
   // clock and reset
   input  wire        SYS_CLK,
   input  wire        ARST_N,
   // ahb-lite slave
   input  wire        HSEL,
   input  wire [11:0] HADDR,
   input  wire [1:0]  HTRANS,
   input  wire        HWRITE,
   input  wire [2:0]  HSIZE,
   input  wire [31:0] HWDATA,
   input  wire        HREADY,
   output wire [31:0] HRDATA,
   output wire        HREADYOUT,
   output wire        HRESP,
   // switch output
   output wire        SWITCH_OUT
);
   // ==========================================
   // storage
   reg  [16:0] ent_on_mem  [0:ENTRIES-1];
   reg  [16:0] ent_off_mem [0:ENTRIES-1];
   reg  [19:0] ent_date_mem[0:ENTRIES-1];
   reg  [2:0]  ent_dlo_mem [0:ENTRIES-1];
   reg  [2:0]  ent_dhi_mem [0:ENTRIES-1];
   reg         ph_wr_ff;
   reg  [11:0] ph_addr_ff;
   reg  [31:0] rdata_ff;
   reg         day_mode_ff;
   reg         run_ff;
   reg  [16:0] sec_ff;
   reg  [2:0]  wday_ff;
   reg  [19:0] date_ff;
   reg  [6:0]  idx_ff;
   reg  [6:0]  scan_ff;
   reg         scanning_ff;
   reg  [31:0] div_ff;
   reg         out_ff;
   reg  [31:0] nxt_rdata;
   wire        tick;
   wire        acc;
   wire [6:0]  last_idx;
   wire        sel;
   wire        on_hit;
   wire        off_hit;

   localparam [31:0] LAST_FULL = ENTRIES - 1;

   function day_in_range;
      input [2:0] d;
      input [2:0] lo;
      input [2:0] hi;
      begin
         day_in_range = (d >= lo) && (d <= hi);
      end
   endfunction

   // setpoint inside one day; 24:00:00 and above means not programmed
   function time_set;
      input [16:0] t;
      begin
         time_set = (t != `WTS_UNSET_TIME) && (t < `WTS_DAY_SECONDS);
      end
   endfunction

   // an edge is due when a programmed setpoint equals the current second
   function setpoint_hit;
      input [16:0] sp;
      input [16:0] now;
      begin
         setpoint_hit = time_set(sp) && (sp == now);
      end
   endfunction

   // a written time of day past one day restarts at midnight
   function [16:0] day_sec;
      input [16:0] s;
      begin
         day_sec = (s < `WTS_DAY_SECONDS) ? s : 17'h0;
      end
   endfunction

   // a written weekday past the week end stops at the week end
   function [2:0] week_day;
      input [2:0] d;
      begin
         week_day = (d > `WTS_DAY_SUN) ? `WTS_DAY_SUN : d;
      end
   endfunction

   // ==========================================
   // bus slave, zero wait states
   assign acc       = HSEL & HTRANS[1] & HREADY;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign HRDATA    = rdata_ff;
   assign last_idx  = LAST_FULL[6:0];

   always @* begin
      case (HADDR)
         `WTS_REG_CTRL:     nxt_rdata = {30'h0, run_ff, day_mode_ff};
         `WTS_REG_TIME:     nxt_rdata = {12'h0, wday_ff, sec_ff};
         `WTS_REG_DATE:     nxt_rdata = {12'h0, date_ff};
         `WTS_REG_IDX:      nxt_rdata = {25'h0, idx_ff};
         `WTS_REG_ENT_TIME: nxt_rdata = {15'h0, ent_on_mem[idx_ff]};
         `WTS_REG_ENT_OFF:  nxt_rdata = {15'h0, ent_off_mem[idx_ff]};
         `WTS_REG_ENT_DATE: nxt_rdata = {6'h0, ent_dhi_mem[idx_ff], ent_dlo_mem[idx_ff],
                                         ent_date_mem[idx_ff]};
         `WTS_REG_STATUS:   nxt_rdata = {30'h0, scanning_ff, out_ff};
         default:           nxt_rdata = 32'h0;
      endcase
   end

   always @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ph_wr_ff   <= 1'b0;
         ph_addr_ff <= 12'h0;
         rdata_ff   <= 32'h0;
      end else begin
         ph_wr_ff   <= acc & HWRITE;
         ph_addr_ff <= HADDR;
         if (acc && !HWRITE) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // entry writes land in the data phase at the selected index
   always @(posedge SYS_CLK) begin
      if (ph_wr_ff && ph_addr_ff == `WTS_REG_ENT_TIME) begin
         ent_on_mem[idx_ff] <= HWDATA[16:0];
      end
      if (ph_wr_ff && ph_addr_ff == `WTS_REG_ENT_OFF) begin
         ent_off_mem[idx_ff] <= HWDATA[16:0];
      end
      if (ph_wr_ff && ph_addr_ff == `WTS_REG_ENT_DATE) begin
         ent_date_mem[idx_ff] <= HWDATA[19:0];
         ent_dlo_mem[idx_ff]  <= HWDATA[22:20];
         ent_dhi_mem[idx_ff]  <= HWDATA[25:23];
      end
   end

   // ==========================================
   // timekeeping, counts seconds only while the run bit is set, on the always-on supply
   assign tick = (div_ff == TICK_CYCLES - 1);

   always @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         day_mode_ff <= 1'b0;
         run_ff      <= 1'b1;
         sec_ff      <= 17'h0;
         wday_ff     <= `WTS_DAY_MON;
         date_ff     <= 20'h0;
         idx_ff      <= 7'h0;
         div_ff      <= 32'h0;
      end else begin
         div_ff <= tick ? 32'h0 : div_ff + 32'h1;
         if (tick && run_ff) begin
            if (sec_ff == `WTS_DAY_SECONDS - 17'h1) begin
               sec_ff  <= 17'h0;
               date_ff <= date_ff + 20'h1;
               wday_ff <= (wday_ff == `WTS_DAY_SUN) ? `WTS_DAY_MON : wday_ff + 3'h1;
            end else begin
               sec_ff <= sec_ff + 17'h1;
            end
         end
         if (ph_wr_ff) begin
            case (ph_addr_ff)
               `WTS_REG_CTRL: begin
                  day_mode_ff <= HWDATA[`WTS_CTRL_DAYMODE];
                  run_ff      <= HWDATA[`WTS_CTRL_RUN];
               end
               `WTS_REG_TIME: begin
                  sec_ff  <= day_sec(HWDATA[16:0]);
                  wday_ff <= week_day(HWDATA[19:17]);
               end
               `WTS_REG_DATE: date_ff <= HWDATA[19:0];
               `WTS_REG_IDX:  idx_ff  <= (HWDATA[6:0] > last_idx) ? last_idx : HWDATA[6:0];
               default: ;
            endcase
         end
      end
   end

   // ==========================================
   // per-second scan in entry order, later entries override
   assign sel = day_mode_ff ? (ent_date_mem[scan_ff] == date_ff)
                            : day_in_range(wday_ff, ent_dlo_mem[scan_ff],
                                           ent_dhi_mem[scan_ff]);
   assign on_hit  = sel && setpoint_hit(ent_on_mem[scan_ff], sec_ff);
   assign off_hit = sel && setpoint_hit(ent_off_mem[scan_ff], sec_ff);

   always @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         scan_ff     <= 7'h0;
         scanning_ff <= 1'b0;
         out_ff      <= 1'b0;
      end else if (!scanning_ff) begin
         if (tick) begin
            scanning_ff <= 1'b1;
            scan_ff     <= 7'h0;
         end
      end else begin
         if (off_hit) begin
            out_ff <= 1'b0;
         end else if (on_hit) begin
            out_ff <= 1'b1;
         end
         // later entries overwrite the outcome of earlier ones
         if (scan_ff == last_idx) begin
            scanning_ff <= 1'b0;
         end else begin
            scan_ff <= scan_ff + 7'h1;
         end
      end
   end

   assign SWITCH_OUT = out_ff;
endmodule // wts_top

/* File: verification/tb_wts_top.sv */
module tb_wts_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 200;
   logic        SYS_CLK = '0, ARST_N = '0, HSEL = '0, HWRITE = '0;
   logic [11:0] HADDR = '0;
   logic [1:0]  HTRANS = '0;
   logic [2:0]  HSIZE = 3'h2;
   logic [31:0] HWDATA = '0, r;
   wire  [31:0] HRDATA;
   wire         HREADY, HREADYOUT, HRESP, SWITCH_OUT;
   int          failures = 0, n_compared = 0, cyc = 0;
   assign HREADY = HREADYOUT;
   wts_top #(.TICK_CYCLES(TK)) i_wts_top (
      .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SWITCH_OUT(SWITCH_OUT)
   );
   // ==========
   // clock, timeout, report
   always #10 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: %h vs %h", $time, s, e);
      end
   endtask
   // ==========
   // bus and entry tasks
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      HSEL <= 1'h1;
      HTRANS <= 2'h2;
      HADDR <= a;
      HWRITE <= w;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'h1);
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'h1);
      q = HRDATA;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'h1, a, d, r);
   endtask
   task automatic ent(input logic [6:0] i, input logic [2:0] s, e,
                      input logic [16:0] on, off, input logic [19:0] dt);
      wr(12'h00c, {25'h0, i});
      wr(12'h014, {6'h0, e, s, dt});
      wr(12'h010, {15'h0, on});
      wr(12'h020, {15'h0, off});
   endtask
   task automatic tm(input logic [2:0] d, input logic [16:0] s, input logic x);
      wr(12'h004, {12'h0, d, s});
      repeat (4 * TK) @(posedge SYS_CLK);
      chk({31'h0, SWITCH_OUT}, {31'h0, x});
   endtask
   // ==========
   // scenarios
   task automatic t_bus();
      chk({31'h0, SWITCH_OUT}, 32'h0);
      bus(1'h0, 12'h018, '0, r);
      chk(r & 32'h1, 32'h0);
      bus(1'h0, 12'h01c, '0, r);
      chk(r, 32'h0);
      wr(12'h00c, 32'hff);
      bus(1'h0, 12'h00c, '0, r);
      chk(r, 32'h7e);
   endtask
   task automatic t_init();
      for (int i = 0; i < 127; i++) ent(i[6:0], 3'h0, 3'h6, 17'h15180, 17'h15180, 20'h0);
   endtask
   task automatic t_week();
      ent(7'h0, 3'h0, 3'h3, 17'h64, 17'h6e, 20'h0);
      tm(3'h1, 17'h62, 1'h1);
      tm(3'h4, 17'h6c, 1'h1);
      tm(3'h2, 17'h6c, 1'h0);
   endtask
   task automatic t_off();
      tm(3'h0, 17'h62, 1'h1);
      ent(7'h1, 3'h4, 3'h6, 17'h15180, 17'h78, 20'h0);
      tm(3'h5, 17'h76, 1'h0);
   endtask
   task automatic t_late();
      ent(7'h2, 3'h6, 3'h6, 17'h82, 17'h15180, 20'h0);
      ent(7'h3, 3'h6, 3'h6, 17'h15180, 17'h82, 20'h0);
      tm(3'h6, 17'h80, 1'h0);
   endtask
   task automatic t_day();
      wr(12'h000, 32'h3);
      wr(12'h008, 32'h5);
      ent(7'h4, 3'h6, 3'h0, 17'ha0, 17'hb0, 20'h5);
      ent(7'h5, 3'h6, 3'h0, 17'hc0, 17'h15180, 20'h5);
      bus(1'h0, 12'h010, '0, r);
      chk(r, 32'hc0);
      bus(1'h0, 12'h020, '0, r);
      chk(r, 32'h15180);
      tm(3'h6, 17'h9e, 1'h1);
      tm(3'h6, 17'hae, 1'h0);
      wr(12'h008, 32'h6);
      tm(3'h6, 17'hbe, 1'h0);
      wr(12'h000, 32'h2);
      tm(3'h1, 17'h62, 1'h1);
   endtask
   initial begin
      repeat (12) @(posedge SYS_CLK);
      ARST_N <= 1'h1;
      @(posedge SYS_CLK);
      t_bus();
      t_init();
      t_week();
      t_off();
      t_late();
      t_day();
      end_sim();
   end
endmodule // tb_wts_top
bind wts_top wts_sva i_wts_sva (
   .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SWITCH_OUT(SWITCH_OUT)
);

/* File: verification/wts_sva.sv */
module wts_sva (
   // clock and reset
   input wire        SYS_CLK,
   input wire        ARST_N,
   // bus
   input wire        HSEL,
   input wire [11:0] HADDR,
   input wire [1:0]  HTRANS,
   input wire        HWRITE,
   input wire [31:0] HWDATA,
   input wire        HREADY,
   input wire [31:0] HRDATA,
   input wire        HREADYOUT,
   input wire        HRESP,
   // switch
   input wire        SWITCH_OUT
);
   // ==========
   // checks
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   sequence tk; HSEL && HTRANS[1] && HREADY; endsequence
   sequence rd(a); tk ##0 (!HWRITE && HADDR == a); endsequence
   sequence wr_idx; tk ##0 (HWRITE && HADDR == 12'h00c); endsequence
   ready_high_a: assert property (HREADYOUT) else $error("wait state seen");
   resp_okay_a: assert property (!HRESP) else $error("error response seen");
   rdata_hold_a: assert property (!(HSEL && HTRANS[1] && HREADY && !HWRITE) |=> $stable(HRDATA))
      else $error("read data moved");
   unmapped_zero_a: assert property (rd(12'h01c) |=> HRDATA == 32'h0) else $error("bad hole");
   status_out_a: assert property (rd(12'h018) |=> HRDATA[0] == $past(SWITCH_OUT))
      else $error("status differs from output");
   reset_out_a: assert property ($rose(ARST_N) |-> !SWITCH_OUT) else $error("output set");
   reset_data_a: assert property ($rose(ARST_N) |-> HRDATA == 32'h0) else $error("data set");
   idx_clamp_a: assert property (wr_idx ##1 (HWDATA[6:0] > 7'h7e) ##1 rd(12'h00c)
      |=> HRDATA == 32'h7e) else $error("index not clamped");
endmodule // wts_sva
